// [logic/msc_consts.svh]
// constants of the multiscaler sweep control block
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ****************************************************************
// clock and times
// ****************************************************************
`define MSC_CLK_MHZ         40
`define MSC_MIN_BIN_SGL_NS  100
`define MSC_MIN_BIN_DUAL_NS 200
`define MSC_BIN_STEP_NS     25
`define MSC_ADV_GAP_NS      150
`define MSC_ADV_GAP_CYC     ((`MSC_ADV_GAP_NS * `MSC_CLK_MHZ + 999) / 1000)
`define MSC_MIN_SGL_CYC     ((`MSC_MIN_BIN_SGL_NS * `MSC_CLK_MHZ + 999) / 1000)
`define MSC_MIN_DUAL_CYC    ((`MSC_MIN_BIN_DUAL_NS * `MSC_CLK_MHZ + 999) / 1000)

// ****************************************************************
// sweep geometry
// ****************************************************************
`define MSC_ADDR_W          19
`define MSC_MIN_BINS        64
`define MSC_MAX_BINS_SGL    524288
`define MSC_MAX_BINS_DUAL   262144
`define MSC_TAG_LSB         11
`define MSC_TAG_W           8
`define MSC_OFS_SHIFT       6
`define MSC_INPUT_BIT       18

// ****************************************************************
// register word indices (byte address bits 5:2)
// ****************************************************************
`define MSC_REG_CTRL        4'h0
`define MSC_REG_DWELL       4'h1
`define MSC_REG_LENGTH      4'h2
`define MSC_REG_PRESET      4'h3
`define MSC_REG_OFFSET      4'h4
`define MSC_REG_TAGEN       4'h5
`define MSC_REG_STATUS      4'h6
`define MSC_REG_SWEEPS      4'h7
`define MSC_REG_BIN         4'h8
`define MSC_REG_CMD         4'h9

// ctrl fields
`define MSC_CTRL_RUN        0
`define MSC_CTRL_DUAL       1
`define MSC_CTRL_EXTADV     2
`define MSC_CTRL_ABORTEN    3
`define MSC_CTRL_PRESETEN   4
`define MSC_CTRL_LIST       5
// cmd fields
`define MSC_CMD_STEP        0
`define MSC_CMD_CLEAR       1

`define MSC_DWELL_RST       32'h0000_0004
`define MSC_LENGTH_RST      20'h00040
`define MSC_PRESET_RST      32'h0000_0000

`endif

// [logic/msc_pkg.sv]
// types of the multiscaler sweep control block
package msc_pkg;
    typedef enum logic [1:0] {
        MSC_IDLE,
        MSC_ARMED,
        MSC_SWEEP,
        MSC_DONE
    } msc_state_e;

    // one histogram or list write
    typedef struct packed {
        logic        valid;
        logic        list;
        logic [18:0] addr;
        logic [7:0]  count;
    } msc_bin_s;

    // avalon request group
    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
    } msc_av_req_s;
endpackage

// [logic/msc_sweep_ctrl.sv]
// multiscaler sweep sequencer with avalon-mm register slave
//
// How it works
// - dwell timer steps the bin, min 100/200 ns, in 25 ns units.
// - external advance passes two flip-flops before use.
// - accepted external advances are at least 150 ns apart.
// - software command steps the bin by one.
// - 32-bit sweep counter counts every valid trigger.
// - sweep preset spans 1 to 2^32-1 (0 never ends the run), compared against sweep count.
// - abort ends the sweep at the current bin boundary.
// - software offset moves the spectrum in steps of 64 bins.
// - each of 8 port bits enabled as tag, replacing top address bits.
// - port bit 7 maps to address bit 18, bit 0 to bit 11.
// - 19-bit address, 512k bins single, 256k per input dual.
// - single-input keeps 8 tags; long sweeps lose tag bits.
// - dual-input uses one address bit for the input, max 7 tags.
// - tag port sampled at trigger and held for the whole sweep.
// - list mode streams bin data instead of histogramming.
// - sweep length 64 to 512k, 256k in dual, single steps.
// - after the last bin the next trigger is taken at once.
// - event pulses are counted into the current bin.
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"

module msc_sweep_ctrl
    import msc_pkg::*;
#(
    parameter int CNT_W = 8                  // per-bin event counter width
) (
    input  wire logic        ref_clk,        // 40 mhz clock
    input  wire logic        reset_n,        // async reset, low active
    input  wire logic [5:0]  avs_address,    // byte address
    input  wire logic        avs_read,       // read strobe
    input  wire logic        avs_write,      // write strobe
    input  wire logic [31:0] avs_writedata,  // write data
    input  wire logic [3:0]  avs_byteenable, // byte lanes
    output logic [31:0]      avs_readdata,   // read data
    output logic             avs_waitrequest,// stall
    input  wire logic        trig_in,        // sweep start pin
    input  wire logic        abort_in,       // abort pin
    input  wire logic        adv_in,         // external advance pin
    input  wire logic        evt1_in,        // counted events, input 1
    input  wire logic        evt2_in,        // counted events, input 2
    input  wire logic [7:0]  tag_in,         // digital port
    output msc_pkg::msc_bin_s bin1_out,      // closed bin, input 1
    output msc_pkg::msc_bin_s bin2_out,      // closed bin, input 2
    output logic             sweep_active    // sweep running
);
    import msc_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // 8-bit mask of enabled tag bits may lose bits to long sweeps
    function automatic logic [7:0] tag_allow(input logic [19:0] len, input logic dual);
        logic [7:0] m;
        m = 8'hff;
        // a tag bit is free only if bin bits do not reach it
        for (int i = 0; i < `MSC_TAG_W; i++) begin
            if (len > (20'h00800 << i)) begin
                m[i] = 1'b0;
            end
        end
        if (dual) begin
            m[7] = 1'b0;
        end
        return m;
    endfunction

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [7:0] tag1_reg;
    logic [7:0] tag2_reg;
    // two flops per pin; the first is read only by the second
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            tag1_reg  <= 8'h00;
            tag2_reg  <= 8'h00;
        end else begin
            sync1_reg <= {evt2_in, evt1_in, adv_in, abort_in, trig_in};
            sync2_reg <= sync1_reg;
            tag1_reg  <= tag_in;
            tag2_reg  <= tag1_reg;
        end
    end
    logic trig_s, abort_s, adv_s, evt1_s, evt2_s;
    assign trig_s  = sync2_reg[0];
    assign abort_s = sync2_reg[1];
    assign adv_s   = sync2_reg[2];
    assign evt1_s  = sync2_reg[3];
    assign evt2_s  = sync2_reg[4];

    logic [4:0] prev_reg;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= 5'h00;
        end else begin
            prev_reg <= sync2_reg;
        end
    end
    logic trig_rise, adv_rise, evt1_rise, evt2_rise;
    assign trig_rise = trig_s & ~prev_reg[0];
    assign adv_rise  = adv_s & ~prev_reg[2];
    assign evt1_rise = evt1_s & ~prev_reg[3];
    assign evt2_rise = evt2_s & ~prev_reg[4];

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [5:0]  ctrl_reg;
    logic [31:0] dwell_reg;
    logic [19:0] length_reg;
    logic [31:0] preset_reg;
    logic [12:0] offset_reg;
    logic [7:0]  tagen_reg;
    logic        step_cmd_reg;
    logic        clear_cmd_reg;
    logic        wr_hit;
    assign wr_hit = avs_write & ~avs_waitrequest;

    // software writes; one wait cycle per access
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg      <= 6'h00;
            dwell_reg     <= `MSC_DWELL_RST;
            length_reg    <= `MSC_LENGTH_RST;
            preset_reg    <= `MSC_PRESET_RST;
            offset_reg    <= 13'h0000;
            tagen_reg     <= 8'h00;
            step_cmd_reg  <= 1'b0;
            clear_cmd_reg <= 1'b0;
        end else begin
            step_cmd_reg  <= 1'b0;
            clear_cmd_reg <= 1'b0;
            if (wr_hit) begin
                case (avs_address[5:2])
                    `MSC_REG_CTRL:   ctrl_reg   <= 6'(lane_merge({26'h0, ctrl_reg}, avs_writedata,
                                                                 avs_byteenable));
                    `MSC_REG_DWELL:  dwell_reg  <= lane_merge(dwell_reg, avs_writedata, avs_byteenable);
                    `MSC_REG_LENGTH: length_reg <= 20'(lane_merge({12'h0, length_reg}, avs_writedata,
                                                                  avs_byteenable));
                    `MSC_REG_PRESET: preset_reg <= lane_merge(preset_reg, avs_writedata, avs_byteenable);
                    `MSC_REG_OFFSET: offset_reg <= 13'(lane_merge({19'h0, offset_reg}, avs_writedata,
                                                                  avs_byteenable));
                    `MSC_REG_TAGEN:  tagen_reg  <= 8'(lane_merge({24'h0, tagen_reg}, avs_writedata,
                                                                 avs_byteenable));
                    `MSC_REG_CMD: begin
                        step_cmd_reg  <= avs_byteenable[0] & avs_writedata[`MSC_CMD_STEP];
                        clear_cmd_reg <= avs_byteenable[0] & avs_writedata[`MSC_CMD_CLEAR];
                    end
                    default: ;
                endcase
            end
        end
    end

    logic run, dual, extadv, aborten, preseten, listmode;
    assign run      = ctrl_reg[`MSC_CTRL_RUN];
    assign dual     = ctrl_reg[`MSC_CTRL_DUAL];
    assign extadv   = ctrl_reg[`MSC_CTRL_EXTADV];
    assign aborten  = ctrl_reg[`MSC_CTRL_ABORTEN];
    assign preseten = ctrl_reg[`MSC_CTRL_PRESETEN];
    assign listmode = ctrl_reg[`MSC_CTRL_LIST];

    // length clamped into 64 .. 512k (256k dual)
    logic [19:0] len_eff;
    always_comb begin
        len_eff = length_reg;
        if (length_reg < 20'(`MSC_MIN_BINS)) begin
            len_eff = 20'(`MSC_MIN_BINS);
        end else if (dual && length_reg > 20'(`MSC_MAX_BINS_DUAL)) begin
            len_eff = 20'(`MSC_MAX_BINS_DUAL);
        end else if (length_reg > 20'(`MSC_MAX_BINS_SGL)) begin
            len_eff = 20'(`MSC_MAX_BINS_SGL);
        end
    end

    // dwell in 25 ns units, floored at the mode minimum
    logic [31:0] dwell_eff;
    always_comb begin
        dwell_eff = dwell_reg;
        if (dual && dwell_reg < 32'(`MSC_MIN_DUAL_CYC)) begin
            dwell_eff = 32'(`MSC_MIN_DUAL_CYC);
        end else if (dwell_reg < 32'(`MSC_MIN_SGL_CYC)) begin
            dwell_eff = 32'(`MSC_MIN_SGL_CYC);
        end
    end

    // ****************************************************************
    // advance sources
    // ****************************************************************
    logic [31:0] dwell_cnt_reg;
    logic [2:0]  gap_cnt_reg;
    logic        timer_tick;
    logic        ext_tick;
    logic        step;
    msc_state_e  state_reg;
    assign timer_tick = !extadv && (dwell_cnt_reg == dwell_eff - 32'h1);
    assign ext_tick   = extadv && adv_rise && (gap_cnt_reg == 3'h0);
    assign step       = (state_reg == MSC_SWEEP) && (timer_tick || ext_tick || step_cmd_reg);

    // dwell timer restarts at each trigger and step
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dwell_cnt_reg <= 32'h0;
        end else if (state_reg != MSC_SWEEP || step) begin
            dwell_cnt_reg <= 32'h0;
        end else begin
            dwell_cnt_reg <= dwell_cnt_reg + 32'h1;
        end
    end

    // lockout after an accepted edge filters ringing
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_cnt_reg <= 3'h0;
        end else if (ext_tick) begin
            gap_cnt_reg <= 3'(`MSC_ADV_GAP_CYC - 1);
        end else if (gap_cnt_reg != 3'h0) begin
            gap_cnt_reg <= gap_cnt_reg - 3'h1;
        end
    end

    // ****************************************************************
    // sweep sequencer
    // ****************************************************************
    logic [19:0] bin_reg;
    logic [31:0] sweeps_reg;
    logic [7:0]  tag_hold_reg;
    logic        abort_pend_reg;
    logic        last_bin;
    logic        preset_hit;
    assign last_bin   = (bin_reg == len_eff - 20'h1);
    // preset 0 never matches, so the run does not end
    assign preset_hit = preseten && (sweeps_reg == preset_reg) && (sweeps_reg != 32'h0);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= MSC_IDLE;
        end else begin
            case (state_reg)
                MSC_IDLE:  if (run) state_reg <= MSC_ARMED;
                MSC_ARMED: begin
                    if (!run) begin
                        state_reg <= MSC_IDLE;
                    end else if (preset_hit) begin
                        state_reg <= MSC_DONE;
                    end else if (trig_rise) begin
                        state_reg <= MSC_SWEEP;
                    end
                end
                MSC_SWEEP: begin
                    // no dead time: back to armed in the same edge
                    if (step && (last_bin || abort_pend_reg || abort_s && aborten)) begin
                        state_reg <= MSC_ARMED;
                    end
                end
                MSC_DONE:  if (!run) state_reg <= MSC_IDLE;
                default:   state_reg <= MSC_IDLE;
            endcase
        end
    end

    // abort latched so a bin boundary always sees it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            abort_pend_reg <= 1'b0;
        end else if (state_reg != MSC_SWEEP || step) begin
            abort_pend_reg <= 1'b0;
        end else if (aborten && abort_s) begin
            abort_pend_reg <= 1'b1;
        end
    end

    // sweep count; the trigger wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sweeps_reg <= 32'h0;
        end else if (state_reg == MSC_ARMED && run && !preset_hit && trig_rise) begin
            sweeps_reg <= sweeps_reg + 32'h1;
        end else if (clear_cmd_reg) begin
            sweeps_reg <= 32'h0;
        end
    end

    // bin index and tag capture at start
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bin_reg      <= 20'h0;
            tag_hold_reg <= 8'h00;
        end else if (state_reg == MSC_ARMED && trig_rise) begin
            bin_reg      <= 20'h0;
            tag_hold_reg <= tag2_reg & tagen_reg;
        end else if (step) begin
            bin_reg      <= last_bin ? 20'h0 : bin_reg + 20'h1;
        end
    end

    // ****************************************************************
    // event counting and address build
    // ****************************************************************
    logic [CNT_W-1:0] cnt1_reg, cnt2_reg;
    // counts restart at each bin; a step-cycle event goes to the new bin
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt1_reg <= '0;
            cnt2_reg <= '0;
        end else if (state_reg != MSC_SWEEP || step) begin
            cnt1_reg <= (state_reg == MSC_SWEEP) ? CNT_W'(evt1_rise) : '0;
            cnt2_reg <= (state_reg == MSC_SWEEP) ? CNT_W'(evt2_rise) : '0;
        end else begin
            if (evt1_rise && cnt1_reg != '1) cnt1_reg <= cnt1_reg + 1'b1;
            if (evt2_rise && cnt2_reg != '1) cnt2_reg <= cnt2_reg + 1'b1;
        end
    end

    logic [18:0] base_addr;
    logic [7:0]  tag_use;
    logic [18:0] tag_mask;
    always_comb begin
        base_addr = 19'(bin_reg) + 19'({offset_reg, 6'h00});
        tag_use   = tagen_reg & tag_allow(len_eff, dual);
        tag_mask  = {tag_use, 11'h000};
        base_addr = (base_addr & ~tag_mask) | ({tag_hold_reg, 11'h000} & tag_mask);
    end

    // closed bin out; in list mode flagged as a stream word
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bin1_out     <= '0;
            bin2_out     <= '0;
            sweep_active <= 1'b0;
        end else begin
            sweep_active    <= (state_reg == MSC_SWEEP);
            bin1_out.valid  <= step;
            bin1_out.list   <= listmode;
            bin1_out.addr   <= dual ? {1'b0, base_addr[17:0]} : base_addr;
            bin1_out.count  <= 8'(cnt1_reg);
            bin2_out.valid  <= step && dual;
            bin2_out.list   <= listmode;
            bin2_out.addr   <= {1'b1, base_addr[17:0]};
            bin2_out.count  <= 8'(cnt2_reg);
        end
    end

    // ****************************************************************
    // avalon slave answer
    // ****************************************************************
    // one wait cycle keeps read data registered
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address[5:2])
                    `MSC_REG_CTRL:   avs_readdata <= {26'h0, ctrl_reg};
                    `MSC_REG_DWELL:  avs_readdata <= dwell_reg;
                    `MSC_REG_LENGTH: avs_readdata <= {12'h0, length_reg};
                    `MSC_REG_PRESET: avs_readdata <= preset_reg;
                    `MSC_REG_OFFSET: avs_readdata <= {19'h0, offset_reg};
                    `MSC_REG_TAGEN:  avs_readdata <= {24'h0, tagen_reg};
                    `MSC_REG_STATUS: avs_readdata <= {20'h0, tag_hold_reg, abort_pend_reg,
                                                      preset_hit, 2'(state_reg)};
                    `MSC_REG_SWEEPS: avs_readdata <= sweeps_reg;
                    `MSC_REG_BIN:    avs_readdata <= {12'h0, bin_reg};
                    default:         avs_readdata <= 32'h0;
                endcase
            end
        end
    end
endmodule // msc_sweep_ctrl
`default_nettype wire

// [tb/msc_sweep_ctrl_monitor.sv]
// port-level checker of the multiscaler sweep control block
`timescale 1ns/1ps
`default_nettype none
module msc_sweep_ctrl_monitor #(
    parameter int CNT_W = 8                // per-bin counter width
) (
    input wire logic              ref_clk,         // clock
    input wire logic              reset_n,         // async reset
    input wire logic              avs_read,        // read strobe
    input wire logic              avs_write,       // write strobe
    input wire logic [31:0]       avs_readdata,    // read data
    input wire logic              avs_waitrequest, // stall
    input wire logic              trig_in,         // sweep start pin
    input wire msc_pkg::msc_bin_s bin1_out,        // bin, input 1
    input wire msc_pkg::msc_bin_s bin2_out,        // bin, input 2
    input wire logic              sweep_active     // sweep running
);
    import msc_pkg::*;
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered after one wait state");
    AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data moved without a read");
    AST_VALID_PULSE: assert property (bin1_out.valid |=> !bin1_out.valid)
        else $error("bin close pulse wider than one cycle");
    AST_INPUT_BIT: assert property (bin2_out.valid |-> bin1_out.valid && !bin1_out.addr[18]
        && bin2_out.addr[18] && bin1_out.addr[17:0] == bin2_out.addr[17:0])
        else $error("input bins not paired by their address bit");
    AST_BIN_IN_SWEEP: assert property (bin1_out.valid |-> sweep_active)
        else $error("bin closed outside a sweep");
    AST_START_CAUSE: assert property ($rose(sweep_active) |-> $past(trig_in, 2) || $past(trig_in, 3)
        || $past(trig_in, 4) || $past(trig_in, 5))
        else $error("sweep started without a trigger");
    // a sweep always lasts at least one bin; it is a lone cycle only when an abort meets a step in its first cycle
    AST_SWEEP_MIN: assert property ($rose(sweep_active) |-> sweep_active[*2])
        else $error("sweep ended at once");
endmodule // msc_sweep_ctrl_monitor
`default_nettype wire

// [tb/msc_src_model.sv]
// model of the trigger, abort, advance, event and tag sources
`timescale 1ns/1ps
`default_nettype none
module msc_src_model (
    input wire logic  ref_clk, // clock
    output logic [4:0] pins_o, // trig abort adv evt1 evt2
    output logic [7:0] tag_o   // digital port
);
    // ****************************************************************
    // source tasks
    // ****************************************************************
    initial begin
        pins_o = 5'h00;
        tag_o = 8'h00;
    end
    // levels held until changed; abort stays up past a whole bin
    task automatic drive(input int idx, input logic v);
        @(posedge ref_clk);
        pins_o[idx] <= v;
    endtask
    // callers send advance edges 2 cycles apart to exercise the lockout
    task automatic pulse(input int idx, input int hi);
        drive(idx, 1'b1);
        repeat (hi) @(posedge ref_clk);
        pins_o[idx] <= 1'b0;
    endtask
    task automatic set_tag(input logic [7:0] v);
        @(posedge ref_clk);
        tag_o <= v;
    endtask
endmodule // msc_src_model
`default_nettype wire

// [tb/msc_sweep_ctrl_bench.sv]
// self-checking bench of the multiscaler sweep control block
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module msc_sweep_ctrl_bench;
    import msc_pkg::*;
    logic        ref_clk, reset_n, rd, wr, wreq, act;
    logic [5:0]  adr;
    logic [31:0] wdat, rdat, q;
    logic [4:0]  pins;
    logic [7:0]  tag;
    logic [18:0] last1;
    msc_bin_s    b1, b2;
    int miscompares = 0, cmp_count = 0, cyc = 0, n1 = 0, n2 = 0, sum1 = 0, t0 = 0, t1 = 0, k, i, sum2 = 0;
    msc_sweep_ctrl #(.CNT_W(8)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf), .avs_readdata(rdat),
        .avs_waitrequest(wreq), .trig_in(pins[0]), .abort_in(pins[1]), .adv_in(pins[2]), .evt1_in(pins[3]),
        .evt2_in(pins[4]), .tag_in(tag), .bin1_out(b1), .bin2_out(b2), .sweep_active(act));
    msc_src_model SRC (.ref_clk(ref_clk), .pins_o(pins), .tag_o(tag));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // bin bookkeeping, hang guard and bus tasks
    // ****************************************************************
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (b1.valid === 1'b1) begin
            n1 <= n1 + 1;
            sum1 <= sum1 + b1.count;
            last1 <= b1.addr;
            t0 <= t1;
            t1 <= cyc;
        end
        if (b2.valid === 1'b1) begin
            n2 <= n2 + 1;
            sum2 <= sum2 + b2.count;
        end
        if (cyc == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one access, held until waitrequest is seen low
    task automatic av(input logic w, input logic [3:0] idx, input logic [31:0] d);
        @(posedge ref_clk);
        rd <= !w;
        wr <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        do @(posedge ref_clk); while (wreq !== 1'b0);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // two spare edges let the bin counters settle
    task automatic wait_act(input logic v);
        while (act !== v) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        {rd, wr, adr, wdat, reset_n} = '0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'b1;
        av(0, `MSC_REG_DWELL, 0); `CHK(q, `MSC_DWELL_RST)
        av(0, `MSC_REG_LENGTH, 0); `CHK(q, {12'h000, `MSC_LENGTH_RST})
        av(0, `MSC_REG_PRESET, 0); `CHK(q, `MSC_PRESET_RST)
        av(0, 4'ha, 0); `CHK(q, 32'h0)
        // timer sweep: bin width, tag capture and event counting
        av(1, `MSC_REG_TAGEN, 32'hff);
        av(1, `MSC_REG_CTRL, 32'h1);
        SRC.set_tag(8'ha5);
        SRC.pulse(0, 3);
        wait_act(1);
        k = n1 + 2;
        while (n1 < k) @(posedge ref_clk);
        `CHK(t1 - t0, 4)
        `CHK(last1[18:11], 8'ha5)
        for (i = 0; i < 5; i++) SRC.pulse(3, 2);
        SRC.set_tag(8'h3d);
        wait_act(0);
        `CHK(n1, 64)
        `CHK(sum1, 5)
        `CHK(last1[18:11], 8'ha5)
        av(0, `MSC_REG_SWEEPS, 0); `CHK(q, 32'h1)
        // external advance with a spike, command step, then abort
        av(1, `MSC_REG_CTRL, 32'hd);
        av(1, `MSC_REG_LENGTH, 32'h1000);
        k = n1;
        SRC.pulse(0, 3);
        wait_act(1);
        SRC.pulse(2, 1);
        SRC.pulse(2, 1);
        repeat (10) @(posedge ref_clk);
        SRC.pulse(2, 1);
        repeat (6) @(posedge ref_clk);
        `CHK(n1 - k, 2)
        av(1, `MSC_REG_CMD, 32'h1);
        repeat (6) @(posedge ref_clk);
        `CHK(n1 - k, 3)
        SRC.drive(1, 1'b1);
        repeat (12) @(posedge ref_clk);
        `CHK(act, 1'b1)
        av(1, `MSC_REG_CMD, 32'h1);
        wait_act(0);
        SRC.drive(1, 1'b0);
        `CHK(n1 - k, 4)
        `CHK(last1[18:11], 8'h3c)
        // dual input with a preset of two sweeps
        av(1, `MSC_REG_CTRL, 32'h0);
        av(1, `MSC_REG_DWELL, 32'h8);
        av(1, `MSC_REG_PRESET, 32'h2);
        av(1, `MSC_REG_LENGTH, 32'h40);
        av(1, `MSC_REG_OFFSET, 32'h1);
        av(1, `MSC_REG_TAGEN, 32'hf);
        av(1, `MSC_REG_CMD, 32'h2);
        av(1, `MSC_REG_CTRL, 32'h33);
        for (i = 0; i < 2; i++) begin
            SRC.pulse(0, 3);
            wait_act(1);
            SRC.pulse(4, 2);
            wait_act(0);
        end
        SRC.pulse(0, 3);
        repeat (20) @(posedge ref_clk);
        `CHK(act, 1'b0)
        `CHK(n2, 128)
        `CHK(last1, 19'h0687f)
        `CHK(sum2, 2)
        `CHK(b1.list, 1'b1)
        av(0, `MSC_REG_SWEEPS, 0); `CHK(q, 32'h2)
        av(0, `MSC_REG_STATUS, 0); `CHK(q[1:0], 2'h3)
        close_out();
    end
endmodule // msc_sweep_ctrl_bench
bind msc_sweep_ctrl msc_sweep_ctrl_monitor #(.CNT_W(CNT_W)) u_mon (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trig_in(trig_in), .bin1_out(bin1_out), .bin2_out(bin2_out), .sweep_active(sweep_active));
`default_nettype wire
